// ---- inc/line_input_consts.svh ----
/*
 * register offsets, field positions, reset values and timing counts for the
 * line-input gain control register bank.
 * assumes: included by bare name from inc/ by the package-using modules.
 */
`ifndef LINE_INPUT_CONSTS_SVH
`define LINE_INPUT_CONSTS_SVH

// register word offsets on the internal register port
`define OFS_POWER_ENABLES 7'h02
`define OFS_PAIR1_CTRL 7'h16
`define OFS_PAIR2_CTRL 7'h17
`define OFS_P1A_VOL 7'h18
`define OFS_P1B_VOL 7'h19
`define OFS_P2A_VOL 7'h1A
`define OFS_P2B_VOL 7'h1B
`define OFS_TIMEOUT_CTRL 7'h30

// field positions
`define BIT_ENA_1A 7
`define BIT_ENA_1B 6
`define BIT_ENA_2A 5
`define BIT_ENA_2B 4
`define BIT_DIFF 1
`define BIT_VU 8
`define BIT_MUTE 7
`define BIT_ZC 6
`define BIT_TO_ENA 0

// reset values
`define RST_VOL 3'h3
`define RST_DIFF 1'b1
`define RST_MUTE 1'b1
`define RST_RATE 2'h0

// timeout base period and derived count at 100 MHz
`define CLK_PERIOD_NS 10
`define TIMEOUT_BASE_US 1000
`define TIMEOUT_BASE_CYCLES ((`TIMEOUT_BASE_US * 1000) / `CLK_PERIOD_NS)

`endif

// ---- inc/line_input_pkg.sv ----
/*
 * types for the line-input gain control register bank.
 * assumes: compiled before the src/ modules.
 */
package line_input_pkg;
    typedef logic [2:0] gain_code_t;
    typedef logic [15:0] reg_word_t;
    typedef enum logic [1:0] {ZC_IDLE, ZC_WAIT} zc_state_t;
endpackage

// ---- src/gain_stage_update.sv ----
/*
 * one input gain stage: holds the gain code in force and moves the stored
 * code into force on a load pulse, at once or at the next zero crossing.
 * assumes: load pulse one cycle wide, timeout tick one cycle wide.
 */
`timescale 1ns/1ps
`default_nettype none
`include "line_input_consts.svh"
module gain_stage_update
    import line_input_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire line_input_pkg::gain_code_t stored_code,
    input wire logic zc_sel,
    input wire logic zero_cross,
    input wire logic timeout_tick,
    output line_input_pkg::gain_code_t applied_code,
    output logic pending
);
    import line_input_pkg::*;

    zc_state_t state; // wait state for a zero crossing
    gain_code_t held; // code captured at the load pulse

    // the load captures the code now, so later writes do not leak in
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state <= ZC_IDLE;
            held <= `RST_VOL;
            applied_code <= `RST_VOL;
        end
        else
        begin
            case (state)
                ZC_IDLE:
                begin
                    if (load && !zc_sel)
                        applied_code <= stored_code; // immediate
                    else if (load)
                    begin
                        held <= stored_code; // (R12)
                        state <= ZC_WAIT;
                    end
                end
                ZC_WAIT:
                begin
                    if (load)
                        held <= stored_code; // a newer load replaces the held code
                    else if (zero_cross)
                    begin
                        applied_code <= held; // (R12)
                        state <= ZC_IDLE;
                    end
                    else if (timeout_tick)
                    begin
                        applied_code <= held; // (R13)
                        state <= ZC_IDLE;
                    end
                end
                default:
                    state <= ZC_IDLE;
            endcase
        end
    end

    assign pending = (state == ZC_WAIT);
endmodule
`default_nettype wire

// ---- src/line_input_gain_control.sv ----
/*
 * register bank and gain routing for the two line-input pin pairs.
 * assumes: the serial control port decoder presents one-cycle write strobes
 * and reads with address and 16-bit data; zero-cross detects come from the
 * analogue comparators, already synchronous to sys_clk.
 */
// Notes on behaviour
// (R1) pair one single-ended: positive to 1a, negative to 1b
// (R2) pair two single-ended: positive to 2a, negative to 2b
// (R3) differential select bit 1, resets differential
// (R4) stage enables bits 7..4 of 02h, reset off
// (R5) software enables a stage before using it
// (R6) differential pair: b stage unused, a controls gain
// (R7) software releases input clamps for used paths
// (R8) software enables reference and master bias
// (R9) single-ended a-stage gain six db higher
// (R10) volume bit 7 mutes, resets muted
// (R11) volume bit 6 selects zero-cross gain change
// (R12) zero-cross mode holds change until crossing
// (R13) timeout applies pending change without crossing
// (R14) volume writes store only, gain unchanged
// (R15) load bit applies a and b together
// (R16) load bit is bit 8 of 18h
// (R17) software writes load bit in differential mode
// (R18) volume bits 2:0, reset 011, db tables
// (R19) load bit reads zero, write pulses once
`timescale 1ns/1ps
`default_nettype none
`include "line_input_consts.svh"
module line_input_gain_control
    import line_input_pkg::*;
#(
    parameter int TIMEOUT_BASE = `TIMEOUT_BASE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic reg_rd, // one-cycle read strobe
    input wire logic [6:0] reg_addr,
    input wire line_input_pkg::reg_word_t reg_wdata,
    output line_input_pkg::reg_word_t reg_rdata, // valid the cycle after reg_rd
    input wire logic [3:0] zero_cross, // per stage 1a,1b,2a,2b
    output logic stage_1a_enable,
    output logic stage_1b_enable,
    output logic stage_2a_enable,
    output logic stage_2b_enable,
    output logic pair_one_differential_sel,
    output logic pair_two_differential_sel,
    output logic pair_one_pos_to_1a, // routing switches
    output logic pair_one_neg_to_1a,
    output logic pair_one_neg_to_1b,
    output logic pair_two_pos_to_2a,
    output logic pair_two_neg_to_2a,
    output logic pair_two_neg_to_2b,
    output logic [3:0] stage_mute, // 1a,1b,2a,2b
    output line_input_pkg::gain_code_t gain_stage_1a,
    output line_input_pkg::gain_code_t gain_stage_1b,
    output line_input_pkg::gain_code_t gain_stage_2a,
    output line_input_pkg::gain_code_t gain_stage_2b,
    output logic [3:0] stage_gain_boost // 1a,1b,2a,2b: +6 db on the a stages single-ended, b bits always zero
);
    import line_input_pkg::*;

    // register state below is the software view; the analogue-facing
    // copies live in the output flops further down, one edge behind
    logic [3:0] ena; // stage enables, 1a at bit 3
    logic diff1; // pair one differential
    logic diff2; // pair two differential
    gain_code_t vol [4]; // stored gain codes
    logic [3:0] mute_r; // mute bits
    logic [3:0] zc_r; // zero-cross selects
    logic to_ena; // timeout clock enable
    logic [1:0] to_rate; // timeout rate, base period times 2**rate
    logic pair_one_volume_load; // one-cycle load pulses
    logic pair_two_volume_load;
    logic [31:0] to_cnt; // timeout divider
    logic to_tick; // one-cycle timeout tick
    gain_code_t applied [4]; // codes in force
    logic [3:0] pend; // stage waiting for a crossing
    logic wr_vol1a; // decoded volume writes
    logic wr_vol1b;
    logic wr_vol2a;
    logic wr_vol2b;

    // volume register decodes for the load-pulse logic; the store logic decodes its own
    assign wr_vol1a = reg_wr && reg_addr == `OFS_P1A_VOL;
    assign wr_vol1b = reg_wr && reg_addr == `OFS_P1B_VOL;
    assign wr_vol2a = reg_wr && reg_addr == `OFS_P2A_VOL;
    assign wr_vol2b = reg_wr && reg_addr == `OFS_P2B_VOL;

    // enables and pair configuration
    // the pending flags at 30h are read-only, so only enable and rate are
    // stored; a write to any other offset leaves these untouched
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ena <= 4'h0; // (R4)
            diff1 <= `RST_DIFF; // (R3)
            diff2 <= `RST_DIFF; // (R3)
            to_ena <= 1'b0;
            to_rate <= `RST_RATE;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `OFS_POWER_ENABLES:
                    ena <= reg_wdata[`BIT_ENA_1A:`BIT_ENA_2B]; // (R4)
                `OFS_PAIR1_CTRL:
                    diff1 <= reg_wdata[`BIT_DIFF]; // (R3)
                `OFS_PAIR2_CTRL:
                    diff2 <= reg_wdata[`BIT_DIFF]; // (R3)
                `OFS_TIMEOUT_CTRL:
                begin
                    to_ena <= reg_wdata[`BIT_TO_ENA];
                    to_rate <= reg_wdata[2:1];
                end
                default:
                    ; // other offsets are not this block's
            endcase
        end
    end

    // volume fields: writing only stores the code
    // mute and zero-cross select take effect at once; only the code waits
    // for a load pulse, so a slow host can stage a and b in two writes
    // stage order in the arrays is 1a,1b,2a,2b; the bit vectors run the
    // other way, 1a at bit 3, to match the output ports
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
                vol[i] <= `RST_VOL; // (R18)
            mute_r <= 4'hF; // (R10)
            zc_r <= 4'h0; // (R11)
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (reg_wr && reg_addr == 7'(`OFS_P1A_VOL + i))
                begin
                    vol[i] <= reg_wdata[2:0]; // (R14)
                    mute_r[3 - i] <= reg_wdata[`BIT_MUTE]; // (R10)
                    zc_r[3 - i] <= reg_wdata[`BIT_ZC]; // (R11)
                end
            end
        end
    end

    // the load bit keeps no state; either volume register of a pair carries it
    // a write with bit 8 clear gives no pulse, so software can rewrite a
    // field without disturbing the gain in force
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pair_one_volume_load <= 1'b0;
            pair_two_volume_load <= 1'b0;
        end
        else
        begin
            pair_one_volume_load <= (wr_vol1a || wr_vol1b) && reg_wdata[`BIT_VU]; // (R16) (R19)
            pair_two_volume_load <= (wr_vol2a || wr_vol2b) && reg_wdata[`BIT_VU]; // (R19)
        end
    end

    // timeout divider: runs only while some stage waits and restarts when
    // none does; one divider serves all four stages, so a stage that starts
    // waiting while another already waits may fall back after less than a
    // full period, traded against four separate counters
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            to_cnt <= 32'h0000_0000;
            to_tick <= 1'b0;
        end
        else if (!to_ena || pend == 4'h0)
        begin
            to_cnt <= 32'h0000_0000;
            to_tick <= 1'b0;
        end
        else if (to_cnt >= 32'((TIMEOUT_BASE << to_rate) - 1))
        begin
            to_cnt <= 32'h0000_0000;
            to_tick <= 1'b1; // (R13)
        end
        else
        begin
            to_cnt <= to_cnt + 32'h0000_0001;
            to_tick <= 1'b0;
        end
    end

    // a and b of a pair share one load pulse, so they move together when both are in immediate mode
    // each stage keeps its own wait state, so a crossing on one stage never
    // applies a code held by another
    for (genvar g = 0; g < 4; g++)
    begin : g_stage
        gain_stage_update u_stage (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .load(g < 2 ? pair_one_volume_load : pair_two_volume_load), // (R15)
            .stored_code(vol[g]),
            .zc_sel(zc_r[3 - g]),
            .zero_cross(zero_cross[3 - g]),
            .timeout_tick(to_tick),
            .applied_code(applied[g]),
            .pending(pend[3 - g])
        );
    end

    // analogue control outputs, all registered
    // one extra edge of delay against the registers keeps every analogue
    // control free of decode glitches, straight from a flop
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            {stage_1a_enable, stage_1b_enable, stage_2a_enable, stage_2b_enable} <= 4'h0;
            pair_one_differential_sel <= `RST_DIFF;
            pair_two_differential_sel <= `RST_DIFF;
            stage_mute <= 4'hF;
            gain_stage_1a <= `RST_VOL;
            gain_stage_1b <= `RST_VOL;
            gain_stage_2a <= `RST_VOL;
            gain_stage_2b <= `RST_VOL;
        end
        else
        begin
            // b stage of a differential pair is unused: its enable is the
            // software's choice, but no pin reaches it
            {stage_1a_enable, stage_1b_enable, stage_2a_enable, stage_2b_enable} <= ena; // (R4)
            pair_one_differential_sel <= diff1;
            pair_two_differential_sel <= diff2;
            stage_mute <= mute_r; // (R10)
            gain_stage_1a <= applied[0]; // (R18)
            gain_stage_1b <= applied[1];
            gain_stage_2a <= applied[2];
            gain_stage_2b <= applied[3];
        end
    end

    // pin routing follows the pair mode
    // differential: the negative pin joins stage a and stage b sees no pin;
    // single-ended: the pair splits across the two stages
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pair_one_pos_to_1a <= 1'b1;
            pair_one_neg_to_1a <= 1'b1;
            pair_one_neg_to_1b <= 1'b0;
            pair_two_pos_to_2a <= 1'b1;
            pair_two_neg_to_2a <= 1'b1;
            pair_two_neg_to_2b <= 1'b0;
            stage_gain_boost <= 4'h0;
        end
        else
        begin
            pair_one_pos_to_1a <= 1'b1; // positive pin always feeds a
            pair_one_neg_to_1a <= diff1; // (R6)
            pair_one_neg_to_1b <= !diff1; // (R1)
            pair_two_pos_to_2a <= 1'b1;
            pair_two_neg_to_2a <= diff2; // (R6)
            pair_two_neg_to_2b <= !diff2; // (R2)
            // same code gives 6 db more on the a stage when single-ended
            stage_gain_boost <= {!diff1, 1'b0, !diff2, 1'b0}; // (R9)
        end
    end

    // register readback; load bit reads zero
    // reads take one cycle and the data holds until the next read strobe;
    // bits not kept here read zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `OFS_POWER_ENABLES:
                    reg_rdata <= {8'h00, ena, 4'h0};
                `OFS_PAIR1_CTRL:
                    reg_rdata <= {14'h0000, diff1, 1'b0};
                `OFS_PAIR2_CTRL:
                    reg_rdata <= {14'h0000, diff2, 1'b0};
                `OFS_P1A_VOL:
                    reg_rdata <= {8'h00, mute_r[3], zc_r[3], 3'h0, vol[0]}; // (R19)
                `OFS_P1B_VOL:
                    reg_rdata <= {8'h00, mute_r[2], zc_r[2], 3'h0, vol[1]};
                `OFS_P2A_VOL:
                    reg_rdata <= {8'h00, mute_r[1], zc_r[1], 3'h0, vol[2]};
                `OFS_P2B_VOL:
                    reg_rdata <= {8'h00, mute_r[0], zc_r[0], 3'h0, vol[3]};
                // bits 6:3 flag the stages still waiting for a crossing
                `OFS_TIMEOUT_CTRL:
                    reg_rdata <= {9'h000, pend, to_rate, to_ena};
                default:
                    reg_rdata <= 16'h0000; // unmapped reads zero
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- dv/line_input_checker.sv ----
/*
 * concurrent checks on the line-input gain control ports.
 * assumes: bound to line_input_gain_control; one clock, sync active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module line_input_checker
    import line_input_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire line_input_pkg::reg_word_t reg_wdata,
    input wire line_input_pkg::reg_word_t reg_rdata,
    input wire logic [3:0] zero_cross,
    input wire logic stage_1a_enable,
    input wire logic stage_1b_enable,
    input wire logic stage_2a_enable,
    input wire logic stage_2b_enable,
    input wire logic pair_one_differential_sel,
    input wire logic pair_two_differential_sel,
    input wire logic pair_one_pos_to_1a,
    input wire logic pair_one_neg_to_1a,
    input wire logic pair_one_neg_to_1b,
    input wire logic pair_two_pos_to_2a,
    input wire logic pair_two_neg_to_2a,
    input wire logic pair_two_neg_to_2b,
    input wire logic [3:0] stage_mute,
    input wire line_input_pkg::gain_code_t gain_stage_1a,
    input wire line_input_pkg::gain_code_t gain_stage_2a,
    input wire logic [3:0] stage_gain_boost
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // all four enables as one field, 1a first
    wire [3:0] ena = {stage_1a_enable, stage_1b_enable, stage_2a_enable, stage_2b_enable};
    logic to_en; // timeout enable shadow: a tick may legally end a wait early
    always_ff @(posedge sys_clk)
        if (!rst_n)
            to_en <= 1'b0;
        else if (reg_wr && reg_addr == 7'h30)
            to_en <= reg_wdata[0];
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_load(a);
        s_wr(a) ##0 reg_wdata[8];
    endsequence
    AST_RESET_VALS: assert property ($rose(rst_n) |-> ena == 4'h0 &&
        stage_mute == 4'hF && gain_stage_1a == 3'h3 && gain_stage_2a == 3'h3
        && pair_one_differential_sel && pair_two_differential_sel)
        else $error("reset values wrong");
    AST_ENA: assert property (s_wr(7'h02) |-> ##2 ena == $past(reg_wdata[7:4], 2))
        else $error("stage enables do not follow the write");
    AST_DIFF: assert property (s_wr(7'h16) |-> ##2
        pair_one_differential_sel == $past(reg_wdata[1], 2))
        else $error("pair one select does not follow the write");
    AST_ROUTE_ONE: assert property (pair_one_pos_to_1a &&
        pair_one_neg_to_1a == pair_one_differential_sel && pair_one_neg_to_1b == !pair_one_differential_sel)
        else $error("pair one routing wrong");
    AST_ROUTE_TWO: assert property (pair_two_pos_to_2a &&
        pair_two_neg_to_2a == pair_two_differential_sel && pair_two_neg_to_2b == !pair_two_differential_sel)
        else $error("pair two routing wrong");
    AST_BOOST: assert property (stage_gain_boost ==
        {!pair_one_differential_sel, 1'b0, !pair_two_differential_sel, 1'b0})
        else $error("gain boost wrong");
    AST_MUTE: assert property (s_wr(7'h18) |-> ##2 stage_mute[3] == $past(reg_wdata[7], 2))
        else $error("mute does not follow the write");
    AST_LOAD_NOW: assert property (s_load(7'h18) ##0 !reg_wdata[6] |-> ##3
        gain_stage_1a == $past(reg_wdata[2:0], 3))
        else $error("immediate load not applied");
    AST_ZC_HOLD: assert property (s_load(7'h1A) ##0 (reg_wdata[6] && !to_en)
        ##1 (!zero_cross[1]) [*4] |-> gain_stage_2a == $past(gain_stage_2a, 4))
        else $error("gain moved without a crossing");
    AST_VU_READ: assert property (reg_rd && (reg_addr == 7'h18 || reg_addr == 7'h1A)
        |=> !reg_rdata[8])
        else $error("load bit reads back set");
endmodule
`default_nettype wire

// ---- dv/zero_cross_source.sv ----
/*
 * far-side model: the analogue crossing detectors.
 * assumes: fire is driven by the bench, one request per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module zero_cross_source
(
    input wire logic sys_clk,
    input wire logic [3:0] fire,
    output logic [3:0] zero_cross = 4'h0
);
    // one-cycle crossing pulse per request; idle low, a level would re-apply
    always @(posedge sys_clk)
        zero_cross <= fire;
endmodule
`default_nettype wire

// ---- dv/tb_line_input_gain_control.sv ----
/*
 * self-checking bench: register reads and output probes queue notes,
 * a negedge monitor compares them.
 * assumes: design TIMEOUT_BASE shortened to 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_line_input_gain_control;
    import line_input_pkg::*;
    typedef struct {int kind; reg_word_t exp; reg_word_t mask;} note_t;
    logic sys_clk, rst_n, reg_wr, reg_rd, chk_v;
    logic [6:0] reg_addr;
    reg_word_t reg_wdata, reg_rdata;
    logic [3:0] fire, zero_cross, stage_mute, stage_gain_boost;
    logic stage_1a_enable, stage_1b_enable, stage_2a_enable, stage_2b_enable;
    logic pair_one_differential_sel, pair_two_differential_sel;
    logic pair_one_pos_to_1a, pair_one_neg_to_1a, pair_one_neg_to_1b;
    logic pair_two_pos_to_2a, pair_two_neg_to_2a, pair_two_neg_to_2b;
    gain_code_t gain_stage_1a, gain_stage_1b, gain_stage_2a, gain_stage_2b;
    note_t notes[$]; // expected results, oldest first
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] rnd;
    // control outputs and gains packed for the monitor
    wire [15:0] ctl_vec = {stage_1a_enable, stage_1b_enable, stage_2a_enable, stage_2b_enable,
        pair_one_differential_sel, pair_two_differential_sel, pair_one_pos_to_1a,
        pair_one_neg_to_1a, pair_one_neg_to_1b, pair_two_pos_to_2a, pair_two_neg_to_2a,
        pair_two_neg_to_2b, stage_mute};
    wire [15:0] gain_vec = {gain_stage_1a, gain_stage_1b, gain_stage_2a, gain_stage_2b,
        stage_gain_boost};
    line_input_gain_control #(.TIMEOUT_BASE(4)) DUT (.*);
    zero_cross_source far (.sys_clk(sys_clk), .fire(fire), .zero_cross(zero_cross));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic wr(input logic [6:0] a, input reg_word_t d);
        @(negedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input reg_word_t e, input reg_word_t m);
        notes.push_back('{0, e, m});
        @(negedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(negedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    // outputs settle three edges after a write; probe after that
    task automatic probe(input int k, input reg_word_t e, input reg_word_t m);
        notes.push_back('{k, e, m});
        repeat (3) @(negedge sys_clk);
        chk_v <= 1'b1;
        @(negedge sys_clk);
        chk_v <= 1'b0;
    endtask
    task automatic results;
        $display("errors %0d tests %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // monitor: read answers stand the cycle after the strobe
    always @(negedge sys_clk)
    begin
        note_t n;
        reg_word_t got;
        if (reg_rd || chk_v)
        begin
            n = notes.pop_front();
            got = (n.kind == 0) ? reg_rdata : (n.kind == 1) ? ctl_vec : gain_vec;
            tests_run++;
            if ((got & n.mask) !== (n.exp & n.mask))
            begin
                n_errors++;
                $display("unexpected at %0t: kind %0d got %h want %h", $time, n.kind, got, n.exp);
            end
        end
    end
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        fire = 4'h0;
        chk_v = 1'b0;
        rst_n = 1'b0;
        rnd = 8'h43;
        repeat (10) @(negedge sys_clk);
        rst_n <= 1'b1;
        rd(7'h02, 16'h0000, 16'h00F0);
        rd(7'h16, 16'h0002, 16'h0002);
        rd(7'h17, 16'h0002, 16'h0002);
        rd(7'h18, 16'h0083, 16'h01C7);
        rd(7'h05, 16'h0000, 16'hFFFF);
        probe(1, 16'h0F6F, 16'hFFFF);
        probe(2, 16'h6DB0, 16'hFFFF);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            wr(7'h02, {8'h00, rnd});
            rd(7'h02, {8'h00, rnd}, 16'h00F0);
            probe(1, {rnd[7:4], 12'h000}, 16'hF000);
        end
        // stages enabled before use; clamps, reference and bias sit outside
        wr(7'h02, 16'h00F0);
        wr(7'h16, 16'h0000);
        wr(7'h17, 16'h0000);
        probe(1, 16'hF2D0, 16'hFFF0);
        probe(2, 16'h000A, 16'h000F);
        rd(7'h16, 16'h0000, 16'h0002);
        // stored only, then loaded together
        wr(7'h18, 16'h0005);
        wr(7'h19, 16'h0006);
        probe(2, 16'h6DB0, 16'hFFF0);
        probe(1, 16'h0000, 16'h000C);
        wr(7'h18, 16'h0105);
        probe(2, 16'hB9B0, 16'hFFF0);
        rd(7'h18, 16'h0005, 16'h01FF);
        // pair two: a waits for its crossing, b applies at once
        wr(7'h1B, 16'h0001);
        wr(7'h1A, 16'h0142);
        repeat (6) @(negedge sys_clk);
        probe(2, 16'hB990, 16'hFFF0);
        @(negedge sys_clk);
        fire <= 4'b0010;
        @(negedge sys_clk);
        fire <= 4'h0;
        probe(2, 16'hB910, 16'hFFF0);
        // no crossing: timeout of 4 << 3 cycles applies the code
        wr(7'h30, 16'h0007);
        wr(7'h18, 16'h0147);
        probe(2, 16'hB910, 16'hFFF0);
        rd(7'h30, 16'h0047, 16'h007F);
        repeat (40) @(negedge sys_clk);
        probe(2, 16'hF910, 16'hFFF0);
        // back to differential: the host still sets the load bit, here via 19h
        wr(7'h16, 16'h0002);
        wr(7'h19, 16'h0103);
        probe(2, 16'hED12, 16'hFFFF);
        @(negedge sys_clk); // let the monitor take the last note
        results();
    end
    // watchdog well beyond the 180 or so cycles the sequence needs
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        results();
    end
endmodule
bind line_input_gain_control line_input_checker chk (.*);
`default_nettype wire
